/* logic/btgx_defs.vh */
/*
  shared constants for the bit invert instruction execution unit:
  opcode field, access bank split, indexed window limit, phase codes.
  assumes nothing of its surroundings; definitions only.
*/
`ifndef BTGX_DEFS_VH
`define BTGX_DEFS_VH

`define BTGX_OPC_HI        15
`define BTGX_OPC_LO        12
`define BTGX_OPC_INVERT    4'h7
`define BTGX_BIT_HI        11
`define BTGX_BIT_LO        9
`define BTGX_ACC_BIT       8
`define BTGX_ACC_SPLIT     8'h60
`define BTGX_IDX_LIMIT     8'h5f
`define BTGX_HI_BANK       4'hf
`define BTGX_PH_IDLE       2'h0
`define BTGX_PH_READ       2'h1
`define BTGX_PH_PROC       2'h2
`define BTGX_PH_WRITE      2'h3

`endif

/* logic/btgx_exec.v */
/*
  execution unit for the single word bit invert instruction: decodes the
  word, forms the data address, reads the byte, inverts one bit, writes back.
  assumes a synchronous data memory whose read data is valid the cycle after
  mem_rd_o, and an instruction word offered with a one-cycle strobe from logic
  on the same clock.
  assumes bank_select_register_i, ext_set_en_i and index_base_i come from logic
  on the same clock; they are sampled only at the edge that takes the word.
  cycle map, counted from the edge that takes the word:
    cycle 1: mem_rd_o high, mem_addr_o valid, busy_o high
    cycle 2: memory presents the byte on mem_rdata_i; the mask, formed in cycle 1, is held in mask_q
    cycle 3: mem_wr_o high with the inverted byte on mem_wdata_o
    cycle 4: done_o high, busy_o low; a new word may be taken at its edge
  words with another opcode are ignored, as are strobes while busy_o is high;
  no status flag is produced, so none can change.
  limitation: mem_rdata_i is sampled once, at the end of cycle 2, so a memory
  slower than one cycle needs a wait state outside this unit.
*/
// Contract
// - opcode 0111: take bit index, access flag, file address; invert only that bit.
// - access flag 0 resolves the file address within the fixed access bank.
// - access flag 1 forms address from bank_select_register and file field.
// - extended set, flag 0, file at most 5Fh: indexed literal offset addressing.
`include "btgx_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module btgx_exec #(
  parameter ADDR_W = 12
) (
  input  wire              mclk_i,
  input  wire              rst_i,
  input  wire [15:0]       instr_i,
  input  wire              instr_vld_i,
  input  wire [3:0]        bank_select_register_i,
  input  wire              ext_set_en_i,
  input  wire [ADDR_W-1:0] index_base_i,
  input  wire [7:0]        mem_rdata_i,
  output reg  [ADDR_W-1:0] mem_addr_o,
  output reg               mem_rd_o,
  output reg               mem_wr_o,
  output reg  [7:0]        mem_wdata_o,
  output reg               busy_o,
  output reg               done_o
);

  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg [2:0] bit_q;
  reg [7:0] mask_q;

  reg [2:0]        bit_d;
  reg [7:0]        mask_d;
  reg [ADDR_W-1:0] addr_d;
  reg              rd_d;
  reg              wr_d;
  reg [7:0]        wdata_d;
  reg              busy_d;
  reg              done_d;

  function is_invert_word;
    input [15:0] w;
    begin
      is_invert_word = (w[`BTGX_OPC_HI:`BTGX_OPC_LO] == `BTGX_OPC_INVERT);
    end
  endfunction

  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  wire       is_invert = is_invert_word(instr_i);
  wire       acc_flag  = instr_i[`BTGX_ACC_BIT];
  wire [7:0] file_f    = instr_i[7:0];
  // a word is taken only while idle; strobes during busy_o are dropped, not queued,
  // so the decoder must stall itself on busy_o
  wire       accept    = instr_vld_i && is_invert && (phase_q == `BTGX_PH_IDLE);

  // address generation; access bank file addresses below 60h map to bank 0, those from 60h up to the top bank
  // indexed mode adds the file field to index_base_i and wraps at ADDR_W bits
  function [ADDR_W-1:0] form_addr;
    input       a;
    input [7:0] f;
    input [3:0] bank_select_register;
    input       ext;
    input [ADDR_W-1:0] base;
    begin
      form_addr = {ADDR_W{1'b0}};
      if (a) begin
        form_addr[11:0] = {bank_select_register, f};
      end else if (ext && f <= `BTGX_IDX_LIMIT) begin
        form_addr = base + {{(ADDR_W-8){1'b0}}, f};
      end else if (f < `BTGX_ACC_SPLIT) begin
        form_addr[7:0] = f;
      end else begin
        form_addr[11:0] = {`BTGX_HI_BANK, f};
      end
    end
  endfunction

  always @* begin
    phase_d = phase_q;
    case (phase_q)
      `BTGX_PH_IDLE: begin
        if (accept) begin
          phase_d = `BTGX_PH_READ;
        end
      end
      `BTGX_PH_READ: begin
        phase_d = `BTGX_PH_PROC;
      end
      `BTGX_PH_PROC: begin
        phase_d = `BTGX_PH_WRITE;
      end
      `BTGX_PH_WRITE: begin
        phase_d = `BTGX_PH_IDLE;
      end
      default: begin
        phase_d = `BTGX_PH_IDLE;
      end
    endcase
  end

  // control pulses; rd, wr and done drop after one cycle unless set again
  always @* begin
    rd_d   = 1'b0;
    wr_d   = 1'b0;
    done_d = 1'b0;
    busy_d = busy_o;
    case (phase_q)
      `BTGX_PH_IDLE: begin
        if (accept) begin
          rd_d   = 1'b1;
          busy_d = 1'b1;
        end
      end
      `BTGX_PH_READ: begin
        // busy_o stays high through read and process so the decoder stalls
        busy_d = 1'b1;
      end
      `BTGX_PH_PROC: begin
        wr_d   = 1'b1;
        busy_d = 1'b1;
      end
      `BTGX_PH_WRITE: begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      default: begin
        busy_d = 1'b0;
      end
    endcase
  end

  // datapath; address, mask and written byte hold between instructions
  always @* begin
    bit_d   = bit_q;
    mask_d  = mask_q;
    addr_d  = mem_addr_o;
    wdata_d = mem_wdata_o;
    case (phase_q)
      `BTGX_PH_IDLE: begin
        if (accept) begin
          bit_d  = instr_i[`BTGX_BIT_HI:`BTGX_BIT_LO];
          addr_d = form_addr(acc_flag, file_f, bank_select_register_i, ext_set_en_i, index_base_i);
        end
      end
      `BTGX_PH_READ: begin
        mask_d = bit_mask(bit_q);
      end
      `BTGX_PH_PROC: begin
        // only the indexed bit flips; no flags are produced, so status stays untouched
        wdata_d = mem_rdata_i ^ mask_q;
      end
      `BTGX_PH_WRITE: begin
        wdata_d = mem_wdata_o;
      end
      default: begin
        mask_d = 8'h00;
      end
    endcase
  end

  // phase and control flops; every output comes straight from a register
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q  <= `BTGX_PH_IDLE;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      phase_q  <= phase_d;
      mem_rd_o <= rd_d;
      mem_wr_o <= wr_d;
      busy_o   <= busy_d;
      done_o   <= done_d;
    end
  end

  // datapath flops; the reset branch loads constants only
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_q       <= 3'h0;
      mask_q      <= 8'h00;
      mem_addr_o  <= {ADDR_W{1'b0}};
      mem_wdata_o <= 8'h00;
    end else begin
      bit_q       <= bit_d;
      mask_q      <= mask_d;
      mem_addr_o  <= addr_d;
      mem_wdata_o <= wdata_d;
    end
  end

endmodule

`default_nettype wire

/* tb/btgx_exec_assertions.sv */
/* checks on the bit invert unit's ports; assumes binding into btgx_exec */
`timescale 1ns/1ps
`default_nettype none
module btgx_exec_chk #(parameter ADDR_W = 12) (
  input wire logic              mclk_i, rst_i, instr_vld_i, ext_set_en_i,
  input wire logic              mem_rd_o, mem_wr_o, busy_o, done_o,
  input wire logic [15:0]       instr_i,
  input wire logic [3:0]        bank_select_register_i,
  input wire logic [ADDR_W-1:0] index_base_i, mem_addr_o,
  input wire logic [7:0]        mem_rdata_i, mem_wdata_o
);
  wire       acc = instr_vld_i && instr_i[15:12] == 4'h7 && !busy_o;
  wire [7:0] f   = instr_i[7:0];
  wire       idx = ext_set_en_i && f <= 8'h5f;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_rmw_order: assert property (acc |=> mem_rd_o ##2 mem_wr_o ##1 done_o)
    else $error("rmw order");
  chk_one_bit: assert property (mem_wr_o |-> $countones(mem_wdata_o ^ $past(mem_rdata_i)) == 1)
    else $error("bit flip");
  chk_bank_sel: assert property (acc && instr_i[8] |=> mem_addr_o == {$past(bank_select_register_i), $past(f)})
    else $error("bank addr");
  chk_acc_bank: assert property (acc && !instr_i[8] && !idx |=>
    mem_addr_o == {($past(f) >= 8'h60) ? 4'hf : 4'h0, $past(f)}) else $error("access addr");
  chk_idx_addr: assert property (acc && !instr_i[8] && idx |=>
    mem_addr_o == $past(index_base_i) + $past(f)) else $error("indexed addr");
  chk_foreign_op: assert property (instr_vld_i && instr_i[15:12] != 4'h7 && !busy_o |=> !mem_rd_o)
    else $error("foreign opcode");
endmodule
bind btgx_exec btgx_exec_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* tb/tb_btgx_exec.sv */
/* scenarios for the bit invert unit; assumes btgx_exec with ADDR_W 12 */
`timescale 1ns/1ps
`default_nettype none
module tb_btgx_exec;
  logic        mclk_i = 0, rst_i = 1, instr_vld_i = 0, ext_set_en_i = 0, mem_rd_o, mem_wr_o, busy_o, done_o;
  logic [15:0] instr_i = 0;
  logic [3:0]  bank_select_register_i = 0;
  logic [11:0] index_base_i = 0, mem_addr_o;
  logic [7:0]  mem_rdata_i = 0, mem_wdata_o;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  always #50 mclk_i = ~mclk_i;
  btgx_exec u_btgx_exec (.*);
  task chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task op(input [15:0] w, input [3:0] b, input e, input [11:0] x, input [11:0] exp, input [7:0] dat);
    @(posedge mclk_i);
    {instr_i, bank_select_register_i, ext_set_en_i, index_base_i, instr_vld_i, mem_rdata_i} <= {w, b, e, x, 1'b1, 8'h00};
    @(posedge mclk_i);
    instr_vld_i <= 1'b0;
    @(negedge mclk_i);
    chk(mem_rd_o, 12'h1);
    chk(busy_o, 12'h1);
    chk(mem_addr_o, exp);
    @(posedge mclk_i);
    mem_rdata_i <= dat;
    @(posedge mclk_i);
    mem_rdata_i <= ~dat;
    @(negedge mclk_i);
    chk(mem_wr_o, 12'h1);
    chk(mem_wdata_o, dat ^ (8'h01 << w[11:9]));
    @(negedge mclk_i);
    chk(done_o, 12'h1);
    chk(busy_o, 12'h0);
  endtask
  task t_bank;
    op(16'h7d34, 4'h2, 1'b0, 12'h000, 12'h234, 8'h75);
    $display("bank test done");
  endtask
  task t_access;
    op(16'h7050, 4'h2, 1'b0, 12'h000, 12'h050, 8'ha5);
    op(16'h7280, 4'h2, 1'b0, 12'h000, 12'hf80, 8'h3c);
    $display("access test done");
  endtask
  task t_index;
    op(16'h7e5f, 4'h3, 1'b1, 12'h100, 12'h15f, 8'h0f);
    op(16'h7060, 4'h3, 1'b1, 12'h100, 12'hf60, 8'hc3);
    $display("index test done");
  endtask
  task t_ignore;
    @(posedge mclk_i);
    {instr_i, instr_vld_i} <= {16'h6d34, 1'b1};
    @(posedge mclk_i);
    instr_vld_i <= 1'b0;
    @(negedge mclk_i);
    chk(mem_rd_o, 12'h0);
    chk(busy_o, 12'h0);
    $display("ignore test done");
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) if (++cyc > 500) begin
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 0;
    t_bank;
    t_access;
    t_index;
    t_ignore;
    give_verdict;
  end
endmodule
`default_nettype wire
